// ### hw/cgu_pkg.sv
// constants and types of the pll clock generator control block
// Summary of operation
// - base clock is crystal/2 or vco/2, chosen by software select bit in user mode
// - in user mode bus clock is base clock divided by two
// - in monitor mode the monitor select pin picks the bus clock source
// - oscillator enabled when sim enable or run-in-stop bit is active
// - pll reference clock is the buffered crystal clock
// - reference clock divided by R gives divided reference clock
// - vco divided by 2^P then by N gives the feedback clock
// - phase detector drives up/down pulses from feedback versus reference phase
// - lock detector compares frequencies per divided reference window, sets mode and lock
// - vco center frequency equals L times 2^E times 38.4 kHz
// - acquisition when acquire/track bit clear, tracking otherwise
// - automatic bandwidth lets the lock detector switch filter mode
// - in auto mode acquire/track bit read-only, follows tolerance
// - in auto mode lock flag read-only, follows tolerance
// - in auto mode with irq enable, each lock toggle requests an interrupt
// - in manual mode acquire/track bit is writable and sets filter mode
// - in manual mode lock flag disabled and no interrupts raised
// - on source change wait three edges of each clock, base clock held
// - refuse vco select with pll off, pll off with vco, and both together
// - zero R or N acts as one; zero L disables pll, forces crystal in user mode
package cgu_pkg;
	localparam logic [7:0] CGU_CTRL_OFS = 8'h00;
	localparam logic [7:0] CGU_DIV_OFS = 8'h04;
	localparam logic [7:0] CGU_STAT_OFS = 8'h08;
	localparam logic [7:0] CGU_CTR_OFS = 8'h0c;
	localparam int CGU_PON_BIT = 0;
	localparam int CGU_BCS_BIT = 1;
	localparam int CGU_IE_BIT = 2;
	localparam int CGU_ACQ_BIT = 3;
	localparam int CGU_AUTO_BIT = 4;
	localparam int CGU_R_LSB = 0;
	localparam int CGU_N_LSB = 4;
	localparam int CGU_P_LSB = 16;
	localparam int CGU_E_LSB = 18;
	localparam int CGU_L_LSB = 20;
	localparam logic [31:0] CGU_CTRL_RST = 32'h0000_0010;
	localparam logic [31:0] CGU_DIV_RST = 32'h0000_0011;
	localparam int CGU_NOM_HZ = 38400;
	localparam int CGU_SW_EDGES = 3;
	localparam int CGU_LOCK_WIN = 8;
	localparam int CGU_LOCK_TOL = 1;
	typedef struct packed {
		logic auto_bw;
		logic acquire_track_bit;
		logic lock_irq_enable;
		logic base_clock_select;
		logic pll_power_on;
	} cgu_ctrl_t;
	typedef struct packed {
		logic [7:0] lin_l;
		logic [1:0] exp_e;
		logic [1:0] pre_p;
		logic [11:0] mod_n;
		logic [3:0] ref_r;
	} cgu_div_t;
	typedef enum logic [1:0] {
		CGU_SW_RUN = 2'b00,
		CGU_SW_OLD = 2'b01,
		CGU_SW_NEW = 2'b11
	} cgu_sw_t;
endpackage : cgu_pkg

// ### hw/cgu_ctrl.sv
// pll clock generator control: dividers, phase and lock detect, source switch, ahb-lite regs
`timescale 1ns/1ns
`default_nettype none
module cgu_ctrl import cgu_pkg::*; #(
	parameter int LOCK_WIN = CGU_LOCK_WIN,
	parameter int LOCK_TOL = CGU_LOCK_TOL
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic crystal_clock_in,
	input wire logic vco_clock_in,
	input wire logic monitor_mode_in,
	input wire logic monitor_clock_select_pin_in,
	input wire logic sim_oscillator_enable_in,
	input wire logic osc_run_in_stop_in,
	output logic osc_enable_out,
	output logic pll_reference_clock_out,
	output logic pll_enable_out,
	output logic pump_up_out,
	output logic pump_dn_out,
	output logic track_mode_out,
	output logic base_clock_out,
	output logic bus_clock_out,
	output logic lock_irq_out
);
	// pins from other clocks: two flops, then a third for edge detect
	logic [2:0] xs_ff, vs_ff, ms_ff;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			xs_ff <= 3'h0;
			vs_ff <= 3'h0;
			ms_ff <= 3'h0;
		end else begin
			xs_ff <= {xs_ff[1:0], crystal_clock_in};
			vs_ff <= {vs_ff[1:0], vco_clock_in};
			ms_ff <= {ms_ff[1:0], monitor_clock_select_pin_in};
		end
	end
	logic x_rise, v_rise;
	assign x_rise = xs_ff[1] & ~xs_ff[2];
	assign v_rise = vs_ff[1] & ~vs_ff[2];

	cgu_ctrl_t ctrl_ff, nxt_ctrl;
	cgu_div_t div_ff, nxt_div;
	logic [3:0] rcnt_ff, nxt_rcnt;
	logic [2:0] pcnt_ff, nxt_pcnt;
	logic [11:0] ncnt_ff, nxt_ncnt;
	logic rdv_ff, nxt_rdv, vdv_ff, nxt_vdv;
	logic up_ff, nxt_up, dn_ff, nxt_dn;
	logic [7:0] wref_ff, nxt_wref, wfb_ff, nxt_wfb;
	logic tol_ff, nxt_tol, lock_ff, nxt_lock, irq_ff, nxt_irq;
	cgu_sw_t sw_ff, nxt_sw;
	logic src_ff, nxt_src, want_ff, nxt_want;
	logic [1:0] ecnt_ff, nxt_ecnt;
	logic base_ff, nxt_base, bus_ff, nxt_bus;
	logic ap_ff, nxt_ap, apw_ff, nxt_apw;
	logic [7:0] apa_ff, nxt_apa;
	logic [31:0] rd_ff, nxt_rd;
	logic osc_ff, refc_ff, pen_ff;

	logic pll_ok, want, src_rise;
	logic [3:0] r_eff;
	logic [11:0] n_eff;
	logic [2:0] p_top;
	logic [31:0] center_hz;
	logic [7:0] fb_next;
	cgu_ctrl_t wc;
	// a zero L keeps the pll off whatever software wrote
	assign pll_ok = ctrl_ff.pll_power_on & (div_ff.lin_l != 8'h00);
	assign r_eff = (div_ff.ref_r == 4'h0) ? 4'h1 : div_ff.ref_r;
	assign n_eff = (div_ff.mod_n == 12'h000) ? 12'h001 : div_ff.mod_n;
	assign p_top = 3'((4'h1 << div_ff.pre_p) - 4'h1);
	assign center_hz = 32'(div_ff.lin_l) * 32'(CGU_NOM_HZ) << div_ff.exp_e;
	assign want = monitor_mode_in ? ms_ff[1] : (ctrl_ff.base_clock_select & pll_ok);
	assign src_rise = src_ff ? v_rise : x_rise;
	assign fb_next = (wfb_ff == 8'hff) ? wfb_ff : wfb_ff + 8'h01;

	always_comb begin
		wc = cgu_ctrl_t'(hwdata_in[4:0]);
		nxt_ctrl = ctrl_ff;
		nxt_div = div_ff;
		nxt_ap = hready_in & hsel_in & htrans_in[1];
		nxt_apw = hwrite_in;
		nxt_apa = haddr_in[7:0];
		nxt_rd = rd_ff;
		if (ap_ff && apw_ff && apa_ff == CGU_CTRL_OFS) begin
			nxt_ctrl.auto_bw = wc.auto_bw;
			nxt_ctrl.lock_irq_enable = wc.lock_irq_enable;
			// only a manual-mode write reaches the filter mode bit
			if (!wc.auto_bw)
				nxt_ctrl.acquire_track_bit = wc.acquire_track_bit;
			// power and select never move together; vco needs power on and nonzero L
			if (wc.pll_power_on == ctrl_ff.pll_power_on ||
				wc.base_clock_select == ctrl_ff.base_clock_select) begin
				if (!(wc.base_clock_select && (!wc.pll_power_on || div_ff.lin_l == 8'h00)))
					nxt_ctrl.base_clock_select = wc.base_clock_select;
				if (!(ctrl_ff.base_clock_select && !wc.pll_power_on))
					nxt_ctrl.pll_power_on = wc.pll_power_on;
			end
		end
		if (ap_ff && apw_ff && apa_ff == CGU_DIV_OFS)
			nxt_div = cgu_div_t'(hwdata_in[27:0]);
		if (div_ff.lin_l == 8'h00)
			nxt_ctrl.base_clock_select = 1'b0;
		// in auto mode the detector owns the mode bit
		if (nxt_ctrl.auto_bw)
			nxt_ctrl.acquire_track_bit = tol_ff;
		if (nxt_ap) begin
			unique case (haddr_in[7:0])
				CGU_CTRL_OFS: nxt_rd = {27'h0, ctrl_ff};
				CGU_DIV_OFS: nxt_rd = {4'h0, div_ff};
				CGU_STAT_OFS: nxt_rd = {28'h0, sw_ff != CGU_SW_RUN, src_ff, tol_ff, lock_ff};
				CGU_CTR_OFS: nxt_rd = center_hz;
				default: nxt_rd = 32'h0;
			endcase
		end
	end

	always_comb begin
		nxt_rcnt = rcnt_ff;
		nxt_rdv = 1'b0;
		nxt_pcnt = pcnt_ff;
		nxt_ncnt = ncnt_ff;
		nxt_vdv = 1'b0;
		if (x_rise) begin
			// reference clock is the crystal clock, divided modulo R
			nxt_rcnt = (rcnt_ff + 4'h1 >= r_eff) ? 4'h0 : rcnt_ff + 4'h1;
			nxt_rdv = (rcnt_ff + 4'h1 >= r_eff) && pll_ok;
		end
		if (v_rise && pll_ok) begin
			nxt_pcnt = (pcnt_ff >= p_top) ? 3'h0 : pcnt_ff + 3'h1;
			if (pcnt_ff >= p_top) begin
				nxt_ncnt = (ncnt_ff + 12'h001 >= n_eff) ? 12'h000 : ncnt_ff + 12'h001;
				nxt_vdv = ncnt_ff + 12'h001 >= n_eff;
			end
		end
		// tri-state style detector: the early edge pumps until the late one arrives
		nxt_up = (up_ff | rdv_ff) & ~(dn_ff | vdv_ff) & pll_ok;
		nxt_dn = (dn_ff | vdv_ff) & ~(up_ff | rdv_ff) & pll_ok;
		if (up_ff && vdv_ff)
			nxt_up = 1'b0;
		if (dn_ff && rdv_ff)
			nxt_dn = 1'b0;
		nxt_wref = wref_ff;
		nxt_wfb = vdv_ff ? fb_next : wfb_ff;
		nxt_tol = tol_ff;
		if (!pll_ok) begin
			nxt_wref = 8'h00;
			nxt_wfb = 8'h00;
			nxt_tol = 1'b0;
		end else if (rdv_ff) begin
			nxt_wref = wref_ff + 8'h01;
			if (wref_ff + 8'h01 == 8'(LOCK_WIN)) begin
				// window closes each LOCK_WIN reference periods
				nxt_tol = (nxt_wfb <= 8'(LOCK_WIN + LOCK_TOL)) &&
					(nxt_wfb + 8'(LOCK_TOL) >= 8'(LOCK_WIN));
				nxt_wref = 8'h00;
				nxt_wfb = 8'h00;
			end
		end
		nxt_lock = ctrl_ff.auto_bw & tol_ff;
		// a toggle always wins; there is no flag to clear
		nxt_irq = ctrl_ff.auto_bw & ctrl_ff.lock_irq_enable & (nxt_lock != lock_ff);
	end

	always_comb begin
		nxt_sw = sw_ff;
		nxt_src = src_ff;
		nxt_want = want_ff;
		nxt_ecnt = ecnt_ff;
		nxt_base = base_ff;
		nxt_bus = bus_ff;
		unique case (sw_ff)
			CGU_SW_RUN: begin
				if (src_rise)
					nxt_base = ~base_ff;
				if (want != src_ff) begin
					nxt_want = want;
					nxt_sw = CGU_SW_OLD;
					nxt_ecnt = 2'h0;
				end
			end
			CGU_SW_OLD: begin
				// base clock frozen while the old source drains
				if (src_rise) begin
					nxt_ecnt = ecnt_ff + 2'h1;
					if (ecnt_ff == 2'(CGU_SW_EDGES - 1)) begin
						nxt_src = want_ff;
						nxt_ecnt = 2'h0;
						nxt_sw = CGU_SW_NEW;
					end
				end
			end
			CGU_SW_NEW: begin
				if (src_rise) begin
					nxt_ecnt = ecnt_ff + 2'h1;
					if (ecnt_ff == 2'(CGU_SW_EDGES - 1))
						nxt_sw = CGU_SW_RUN;
				end
			end
			default: nxt_sw = CGU_SW_RUN;
		endcase
		if (!base_ff && nxt_base)
			nxt_bus = ~bus_ff;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_ff <= cgu_ctrl_t'(CGU_CTRL_RST[4:0]);
			div_ff <= cgu_div_t'(CGU_DIV_RST[27:0]);
			rcnt_ff <= 4'h0;
			pcnt_ff <= 3'h0;
			ncnt_ff <= 12'h000;
			rdv_ff <= 1'b0;
			vdv_ff <= 1'b0;
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
			wref_ff <= 8'h00;
			wfb_ff <= 8'h00;
			tol_ff <= 1'b0;
			lock_ff <= 1'b0;
			irq_ff <= 1'b0;
			sw_ff <= CGU_SW_RUN;
			src_ff <= 1'b0;
			want_ff <= 1'b0;
			ecnt_ff <= 2'h0;
			base_ff <= 1'b0;
			bus_ff <= 1'b0;
			ap_ff <= 1'b0;
			apw_ff <= 1'b0;
			apa_ff <= 8'h00;
			rd_ff <= 32'h0;
			osc_ff <= 1'b0;
			refc_ff <= 1'b0;
			pen_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			div_ff <= nxt_div;
			rcnt_ff <= nxt_rcnt;
			pcnt_ff <= nxt_pcnt;
			ncnt_ff <= nxt_ncnt;
			rdv_ff <= nxt_rdv;
			vdv_ff <= nxt_vdv;
			up_ff <= nxt_up;
			dn_ff <= nxt_dn;
			wref_ff <= nxt_wref;
			wfb_ff <= nxt_wfb;
			tol_ff <= nxt_tol;
			lock_ff <= nxt_lock;
			irq_ff <= nxt_irq;
			sw_ff <= nxt_sw;
			src_ff <= nxt_src;
			want_ff <= nxt_want;
			ecnt_ff <= nxt_ecnt;
			base_ff <= nxt_base;
			bus_ff <= nxt_bus;
			ap_ff <= nxt_ap;
			apw_ff <= nxt_apw;
			apa_ff <= nxt_apa;
			rd_ff <= nxt_rd;
			osc_ff <= sim_oscillator_enable_in | osc_run_in_stop_in;
			refc_ff <= xs_ff[1];
			pen_ff <= pll_ok;
		end
	end

	assign hrdata_out = rd_ff;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign osc_enable_out = osc_ff;
	assign pll_reference_clock_out = refc_ff;
	assign pll_enable_out = pen_ff;
	assign pump_up_out = up_ff;
	assign pump_dn_out = dn_ff;
	assign track_mode_out = ctrl_ff.acquire_track_bit;
	assign base_clock_out = base_ff;
	assign bus_clock_out = bus_ff;
	assign lock_irq_out = irq_ff;

	held_base_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		sw_ff != CGU_SW_RUN |=> $stable(base_ff)) else $error("base clock moved during switch");
	bus_half_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(base_ff) |-> bus_ff != $past(bus_ff)) else $error("bus clock missed base edge");
	osc_en_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(sim_oscillator_enable_in | osc_run_in_stop_in) |=> osc_enable_out) else $error("osc not on");
	manual_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!ctrl_ff.auto_bw ##1 !ctrl_ff.auto_bw |-> !lock_ff && !irq_ff) else $error("manual lock");
	auto_irq_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ctrl_ff.auto_bw && ctrl_ff.lock_irq_enable && tol_ff != lock_ff |=> irq_ff)
		else $error("lock toggle gave no irq");
	auto_acq_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ctrl_ff.auto_bw ##1 ctrl_ff.auto_bw |-> ctrl_ff.acquire_track_bit == $past(tol_ff))
		else $error("acq bit not tolerance");
	no_vco_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		ctrl_ff.base_clock_select |-> ctrl_ff.pll_power_on) else $error("vco selected, pll off");
	zero_l_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		div_ff.lin_l == 8'h00 |=> !pll_enable_out ##1 !ctrl_ff.base_clock_select)
		else $error("zero L left pll on");
	pump_excl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!(pump_up_out && pump_dn_out)) else $error("both pumps on");
	switch_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		sw_ff == CGU_SW_NEW ##1 sw_ff == CGU_SW_RUN && src_ff);
	lock_c: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(lock_ff));
	irq_c: cover property (@(posedge clk_in) disable iff (sys_rst_in) irq_ff);
endmodule : cgu_ctrl
`default_nettype wire

// ### test/cgu_ctrl_tb.sv
// random and directed testbench of the clock generator control block
`timescale 1ns/1ns
`default_nettype none
module cgu_ctrl_tb import cgu_pkg::*; ;
	logic clk_in = 0;
	logic rst = 1;
	logic hsel = 0;
	logic hwr = 0;
	logic xtal = 0;
	logic vco = 0;
	logic mon = 0;
	logic mpin = 0;
	logic sosc = 0;
	logic ostp = 0;
	logic both = 0;
	logic [1:0] htr = 2'h0;
	logic [31:0] ha = 32'h0;
	logic [31:0] hwd = 32'h0;
	logic [31:0] r;
	logic [31:0] d;
	wire [31:0] hrd;
	wire hro, hresp, oen, refc, pen, pup, pdn, trk, basec, busc, irq;
	int seed = 32'hae1a;
	int n_fail = 0;
	int checked = 0;
	int xh = 6;
	int vh = 3;
	int xc = 0;
	int vc = 0;
	int nirq = 0;
	int k;

	cgu_ctrl dut_u (.clk_in(clk_in), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(ha),
		.htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hready_in(hro),
		.hwdata_in(hwd), .hrdata_out(hrd), .hreadyout_out(hro), .hresp_out(hresp),
		.crystal_clock_in(xtal), .vco_clock_in(vco), .monitor_mode_in(mon),
		.monitor_clock_select_pin_in(mpin), .sim_oscillator_enable_in(sosc),
		.osc_run_in_stop_in(ostp), .osc_enable_out(oen), .pll_reference_clock_out(refc),
		.pll_enable_out(pen), .pump_up_out(pup), .pump_dn_out(pdn), .track_mode_out(trk),
		.base_clock_out(basec), .bus_clock_out(busc), .lock_irq_out(irq));

	initial forever #10 clk_in = ~clk_in;

	// slow external clocks, kept below a quarter of clk_in for the synchronisers
	always @(posedge clk_in) begin
		if (xc >= xh - 1) begin
			xc <= 0;
			xtal <= ~xtal;
		end else xc <= xc + 1;
		if (vc >= vh - 1) begin
			vc <= 0;
			vco <= ~vco;
		end else vc <= vc + 1;
	end

	always @(negedge clk_in) begin
		if (irq === 1'b1) nirq++;
		if (pup === 1'b1 && pdn === 1'b1) both = 1;
	end

	function automatic logic [31:0] ctr_hz(input logic [7:0] l, input logic [1:0] e);
		return (32'(l) << e) * CGU_NOM_HZ;
	endfunction : ctr_hz

	function automatic int tog(input int h);
		return 120 / h;
	endfunction : tog

	task automatic complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic near(input int g, input int e);
		chk((g >= e - 1 && g <= e + 1) ? e : g, e);
	endtask : near

	task automatic rdy();
		int i;
		i = 0;
		do begin
			@(posedge clk_in);
			i++;
		end while (hro !== 1'b1 && i < 20);
		if (hro !== 1'b1) begin
			n_fail++;
			complete_run();
		end
	endtask : rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_in);
		hsel <= 1'b1;
		htr <= 2'h2;
		hwr <= w;
		ha <= {24'h0, a};
		rdy();
		htr <= 2'h0;
		hsel <= 1'b0;
		hwd <= wd;
		rdy();
		r = hrd;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd

	// bounded status poll; running out of reads ends the run
	task automatic poll(input int i, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, CGU_STAT_OFS, 32'h0);
			n++;
		end while (r[i] !== v && n < 300);
		chk({31'h0, r[i]}, {31'h0, v});
		if (r[i] !== v) complete_run();
	endtask : poll

	// edge counts over a window; one edge of slack for window alignment
	task automatic cnt(input int h);
		logic pb, pu, pr;
		int b, u, f;
		b = 0;
		u = 0;
		f = 0;
		@(negedge clk_in);
		pb = basec;
		pu = busc;
		pr = refc;
		repeat (240) begin
			@(negedge clk_in);
			if (basec !== pb) b++;
			if (busc !== pu) u++;
			if (refc !== pr) f++;
			pb = basec;
			pu = busc;
			pr = refc;
		end
		near(b, tog(h));
		near(u, tog(h) / 2);
		near(f, 240 / xh);
	endtask : cnt

	task automatic settle();
		repeat (3) @(negedge clk_in);
	endtask : settle

	initial begin
		repeat (5) @(posedge clk_in);
		rst <= 1'b0;
		rd(CGU_CTRL_OFS, CGU_CTRL_RST);
		rd(CGU_DIV_OFS, CGU_DIV_RST);
		rd(8'h10, 32'h0);
		rd(CGU_CTR_OFS, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		repeat (8) begin
			@(posedge clk_in);
			{sosc, ostp} <= 2'($random(seed));
			@(posedge clk_in);
			@(negedge clk_in);
			chk({31'h0, oen}, {31'h0, sosc | ostp});
		end
		bus(1'b1, CGU_CTRL_OFS, 32'h11);
		settle();
		chk({31'h0, pen}, 32'h0);
		bus(1'b1, CGU_CTRL_OFS, 32'h13);
		rd(CGU_CTRL_OFS, 32'h11);
		bus(1'b1, CGU_CTRL_OFS, 32'h10);
		for (k = 0; k < 5; k++) begin
			d = (k == 0) ? 32'h2ff : $random(seed);
			d[7:0] = d[7:0] | 8'h01;
			d[9:8] = d[9] ? 2'h2 : {1'b0, d[8]};
			bus(1'b1, CGU_DIV_OFS, {4'h0, d[7:0], d[9:8], 2'h0, 12'h001, 4'h1});
			rd(CGU_CTR_OFS, ctr_hz(d[7:0], d[9:8]));
		end
		// zero R must behave as one, or the loop cannot lock
		bus(1'b1, CGU_DIV_OFS, {4'h0, 8'h80, 2'h1, 2'h0, 12'h002, 4'h0});
		bus(1'b1, CGU_CTRL_OFS, 32'h13);
		rd(CGU_CTRL_OFS, 32'h10);
		nirq = 0;
		bus(1'b1, CGU_CTRL_OFS, 32'h15);
		poll(0, 1'b1);
		settle();
		chk({31'h0, pen}, 32'h1);
		chk({31'h0, trk}, 32'h1);
		chk(32'(nirq), 32'h1);
		cnt(xh);
		bus(1'b1, CGU_CTRL_OFS, 32'h17);
		poll(2, 1'b1);
		poll(3, 1'b0);
		cnt(vh);
		bus(1'b1, CGU_CTRL_OFS, 32'h16);
		rd(CGU_CTRL_OFS, 32'h1f);
		bus(1'b1, CGU_CTRL_OFS, 32'h15);
		poll(2, 1'b0);
		poll(3, 1'b0);
		vh = 4;
		poll(0, 1'b0);
		settle();
		chk({31'h0, trk}, 32'h0);
		chk(32'(nirq), 32'h2);
		vh = 3;
		// manual bring-up: power off, clear the filter bit, power on, acquire, then track
		bus(1'b1, CGU_CTRL_OFS, 32'h14);
		bus(1'b1, CGU_CTRL_OFS, 32'h04);
		bus(1'b1, CGU_CTRL_OFS, 32'h05);
		settle();
		chk({31'h0, trk}, 32'h0);
		repeat (300) @(negedge clk_in);
		bus(1'b1, CGU_CTRL_OFS, 32'h0d);
		settle();
		chk({31'h0, trk}, 32'h1);
		repeat (300) @(negedge clk_in);
		bus(1'b0, CGU_STAT_OFS, 32'h0);
		chk({31'h0, r[0]}, 32'h0);
		chk(32'(nirq), 32'h2);
		bus(1'b1, CGU_CTRL_OFS, 32'h0f);
		poll(2, 1'b1);
		poll(3, 1'b0);
		// pin must clear its synchroniser before monitor mode reads it, or a false switch starts
		@(posedge clk_in);
		mpin <= 1'b1;
		repeat (3) @(posedge clk_in);
		mon <= 1'b1;
		repeat (80) @(negedge clk_in);
		cnt(vh);
		@(posedge clk_in);
		mpin <= 1'b0;
		repeat (80) @(negedge clk_in);
		cnt(xh);
		chk({31'h0, both}, 32'h0);
		complete_run();
	end
endmodule : cgu_ctrl_tb
`default_nettype wire
